// ==== misc_regs_pkg.sv ====
// constants, field layout and carrier types for the misc control register bank
package misc_regs_pkg;

  // bus geometry
  localparam int ADDR_W = 14;
  localparam int IDX_W  = ADDR_W - 2;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PAGE       = 12'h008;
  localparam logic [IDX_W-1:0] IDX_LINK_EN_LO = 12'h597;
  localparam logic [IDX_W-1:0] IDX_LINK_EN_HI = 12'h598;
  localparam logic [IDX_W-1:0] IDX_FLUSH      = 12'h599;
  localparam logic [IDX_W-1:0] IDX_BOOT       = 12'h705;
  localparam logic [IDX_W-1:0] IDX_SYNTH_PD0  = 12'h790;
  localparam logic [IDX_W-1:0] IDX_SYNTH_PD1  = 12'h791;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h7f0;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  = 12'h7f1;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 12'h7f2;
  localparam logic [1:0]       WORD_ALIGN     = 2'h0;

  // link interrupt sources, one enable bit each
  localparam int NUM_LINK_SRC = 9;
  localparam int LINK_LO_W    = 8;
  localparam int LINK_HI_BIT  = 0;

  // interrupt status layout: link sources, then loader outcomes
  localparam int IRQ_W             = 11;
  localparam int IRQ_BOOT_OK_BIT   = 9;
  localparam int IRQ_BOOT_FAIL_BIT = 10;

  // bit positions
  localparam int FLUSH_BIT      = 0;
  localparam int BOOT_START_BIT = 0;
  localparam int BOOT_DONE_BIT  = 1;

  // reset values
  localparam logic [NUM_LINK_SRC-1:0] LINK_EN_RST   = 9'h000;
  localparam logic [REG_W-1:0]        SYNTH_PD0_RST = 8'h02;
  localparam logic [REG_W-1:0]        SYNTH_PD1_RST = 8'h00;
  localparam logic [IRQ_W-1:0]        IRQ_RST       = 11'h000;
  localparam logic                    FLUSH_RST     = 1'b0;
  localparam logic                    BOOT_RST      = 1'b0;
  localparam logic [DATA_W-1:0]       RD_ZERO       = 32'h0000_0000;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_type;

  // apb answer to the master
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } apb_rsp_type;

  // outcome pulses from the non-volatile boot loader
  typedef struct packed {
    logic finished_ok;
    logic failed;
  } loader_evt_type;

endpackage

// ==== misc_irq_flush_boot_pll_regs.sv ====
// apb register bank: link irq enables, paged flush, boot loader, synth power
// Functional notes
// - nine enable bits, one per link interrupt source, bit 8 down to 0
// - bits 7..0 in low register, bit 8 in next register bit 0; reset zero
// - flush enable bit drives datapath flush; upper bits read zero
// - flush enable banked per converter; page select picks copies reached
// - writing 1 starts boot loader; self clears on completion or failure
// - done bit resets to zero, set only on successful loader completion
module misc_irq_flush_boot_pll_regs
  import misc_regs_pkg::*;
#(
  parameter int NUM_CONV = 2
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  // register bus
  input  wire apb_req_type             apb_req,
  output apb_rsp_type                  apb_rsp,
  // event inputs
  input  wire logic [NUM_LINK_SRC-1:0] link_event,
  input  wire loader_evt_type          loader_evt,
  // control outputs
  output logic                         boot_loader_start,
  output logic [NUM_CONV-1:0]          datapath_flush,
  output logic [REG_W-1:0]             synth_powerdown0,
  output logic [REG_W-1:0]             synth_powerdown1,
  output logic                         irq
);

  logic [NUM_LINK_SRC-1:0] link_irq_enable_bits;
  logic [NUM_CONV-1:0]     main_converter_page_select;
  logic                    boot_loader_done;
  logic [IRQ_W-1:0]        irq_status;
  logic [IRQ_W-1:0]        irq_enable;
  logic [IRQ_W-1:0]        next_irq_status;
  logic [IRQ_W-1:0]        next_irq_enable;
  logic [IRQ_W-1:0]        irq_set;
  logic [IRQ_W-1:0]        irq_clr;
  logic [IDX_W-1:0]        idx;
  logic                    aligned;
  logic                    access;
  logic                    wr_fire;
  logic                    hit;
  logic                    flush_rd;
  logic [DATA_W-1:0]       rd_val;
  logic [REG_W-1:0]        wbyte;

  // access phase decode
  assign idx     = apb_req.paddr[ADDR_W-1:2];
  assign aligned = (apb_req.paddr[1:0] == WORD_ALIGN);
  assign access  = apb_req.psel & apb_req.penable & ~apb_rsp.pready;
  assign wr_fire = apb_req.psel & apb_req.penable & apb_req.pwrite
                   & apb_rsp.pready;
  assign wbyte   = apb_req.pwdata[REG_W-1:0];

  // flush readback comes from the lowest selected converter copy
  always_comb begin
    flush_rd = FLUSH_RST;
    for (int i = NUM_CONV - 1; i >= 0; i--) begin
      if (main_converter_page_select[i]) begin
        flush_rd = datapath_flush[i];
      end
    end
  end

  // read mux and address decode
  always_comb begin
    hit    = aligned;
    rd_val = RD_ZERO;
    if (idx == IDX_PAGE) begin
      rd_val[NUM_CONV-1:0] = main_converter_page_select;
    end else if (idx == IDX_LINK_EN_LO) begin
      rd_val[LINK_LO_W-1:0] = link_irq_enable_bits[LINK_LO_W-1:0];
    end else if (idx == IDX_LINK_EN_HI) begin
      rd_val[LINK_HI_BIT] = link_irq_enable_bits[LINK_LO_W];
    end else if (idx == IDX_FLUSH) begin
      rd_val[FLUSH_BIT] = flush_rd;
    end else if (idx == IDX_BOOT) begin
      rd_val[BOOT_START_BIT] = boot_loader_start;
      rd_val[BOOT_DONE_BIT]  = boot_loader_done;
    end else if (idx == IDX_SYNTH_PD0) begin
      rd_val[REG_W-1:0] = synth_powerdown0;
    end else if (idx == IDX_SYNTH_PD1) begin
      rd_val[REG_W-1:0] = synth_powerdown1;
    end else if (idx == IDX_IRQ_STATUS) begin
      rd_val[IRQ_W-1:0] = irq_status;
    end else if (idx == IDX_IRQ_CLEAR) begin
      rd_val = RD_ZERO; // write-only, reads zero
    end else if (idx == IDX_IRQ_ENABLE) begin
      rd_val[IRQ_W-1:0] = irq_enable;
    end else begin
      hit = 1'b0;
    end
  end

  // apb answer: one wait state, then ready with data or error
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      apb_rsp.prdata  <= RD_ZERO;
      apb_rsp.pready  <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
    end else begin
      apb_rsp.pready  <= access;
      apb_rsp.pslverr <= access & ~hit;
      if (access && hit && !apb_req.pwrite) begin
        apb_rsp.prdata <= rd_val;
      end else begin
        apb_rsp.prdata <= RD_ZERO;
      end
    end
  end

  // main converter page selection
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      main_converter_page_select <= '1;
    end else if (wr_fire && aligned && idx == IDX_PAGE) begin
      main_converter_page_select <= apb_req.pwdata[NUM_CONV-1:0];
    end
  end

  // link interrupt enables split over two registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      link_irq_enable_bits <= LINK_EN_RST;
    end else if (wr_fire && aligned && idx == IDX_LINK_EN_LO) begin
      link_irq_enable_bits[LINK_LO_W-1:0] <= wbyte;
    end else if (wr_fire && aligned && idx == IDX_LINK_EN_HI) begin
      link_irq_enable_bits[LINK_LO_W] <= wbyte[LINK_HI_BIT];
    end
  end

  // banked flush enable, one copy per converter
  generate
    for (genvar c = 0; c < NUM_CONV; c++) begin : g_flush
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          datapath_flush[c] <= FLUSH_RST;
        end else if (wr_fire && aligned && idx == IDX_FLUSH
                     && main_converter_page_select[c]) begin
          datapath_flush[c] <= wbyte[FLUSH_BIT];
        end
      end
    end
  endgenerate

  // boot loader start bit: a write wins, otherwise outcome clears it
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      boot_loader_start <= BOOT_RST;
    end else if (wr_fire && aligned && idx == IDX_BOOT) begin
      boot_loader_start <= wbyte[BOOT_START_BIT];
    end else if (loader_evt.finished_ok || loader_evt.failed) begin
      boot_loader_start <= 1'b0;
    end
  end

  // boot loader done: cleared by a new start, set only on success
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      boot_loader_done <= BOOT_RST;
    end else if (boot_loader_start && loader_evt.finished_ok) begin
      boot_loader_done <= 1'b1;
    end else if (wr_fire && aligned && idx == IDX_BOOT
                 && wbyte[BOOT_START_BIT]) begin
      boot_loader_done <= 1'b0;
    end
  end

  // synthesizer power-down controls, plain read-write
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      synth_powerdown0 <= SYNTH_PD0_RST;
      synth_powerdown1 <= SYNTH_PD1_RST;
    end else if (wr_fire && aligned && idx == IDX_SYNTH_PD0) begin
      synth_powerdown0 <= wbyte;
    end else if (wr_fire && aligned && idx == IDX_SYNTH_PD1) begin
      synth_powerdown1 <= wbyte;
    end
  end

  // sticky status: gated link events and loader outcomes, set beats clear
  always_comb begin
    irq_set = IRQ_RST;
    irq_set[NUM_LINK_SRC-1:0]  = link_event & link_irq_enable_bits;
    irq_set[IRQ_BOOT_OK_BIT]   = boot_loader_start & loader_evt.finished_ok;
    irq_set[IRQ_BOOT_FAIL_BIT] = boot_loader_start & loader_evt.failed;
    irq_clr = IRQ_RST;
    if (wr_fire && aligned && idx == IDX_IRQ_CLEAR) begin
      irq_clr = apb_req.pwdata[IRQ_W-1:0];
    end
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
    next_irq_enable = irq_enable;
    if (wr_fire && aligned && idx == IDX_IRQ_ENABLE) begin
      next_irq_enable = apb_req.pwdata[IRQ_W-1:0];
    end
  end

  // status, enable and the level interrupt output
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_status <= IRQ_RST;
      irq_enable <= IRQ_RST;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      irq        <= |(next_irq_status & next_irq_enable);
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_setup;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence

  sequence s_done;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence

  a_apb_one_wait: assert property (s_setup |=> s_done)
    else $error("apb answer not after exactly one wait state");

  a_unmapped_error: assert property (
    (s_setup and (!hit)) |=> apb_rsp.pslverr && apb_rsp.prdata == RD_ZERO)
    else $error("unmapped access not flagged");

  // bus answer shape
  a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");

  a_rdata_idle: assert property (
    !apb_rsp.pready |-> apb_rsp.prdata == RD_ZERO)
    else $error("read data not zero outside the answer");

  a_link_gate_off: assert property (
    (irq_status[NUM_LINK_SRC-1:0] == 9'h000
     && (link_event & link_irq_enable_bits) == 9'h000)
    |=> irq_status[NUM_LINK_SRC-1:0] == 9'h000)
    else $error("disabled link source reported");

  a_link_event_set: assert property (
    (link_event & link_irq_enable_bits) != 9'h000
    |=> (irq_status[NUM_LINK_SRC-1:0]
         & $past(link_event & link_irq_enable_bits))
        == $past(link_event & link_irq_enable_bits))
    else $error("enabled link event lost");

  a_high_reserved: assert property (
    (s_setup and (idx == IDX_LINK_EN_HI && aligned && !apb_req.pwrite))
    |=> apb_rsp.prdata[DATA_W-1:1] == 31'h0000_0000
        && apb_rsp.prdata[0] == link_irq_enable_bits[LINK_LO_W])
    else $error("link enable high register readback wrong");

  a_enable_reset: assert property (
    disable iff (1'b0) !nrst |=> link_irq_enable_bits == LINK_EN_RST
                                 && synth_powerdown0 == SYNTH_PD0_RST)
    else $error("reset values wrong");

  // reset values of the control outputs
  a_ctrl_reset: assert property (
    disable iff (1'b0) !nrst |=> datapath_flush == '0 && !boot_loader_start
                                 && !boot_loader_done && !irq)
    else $error("control outputs not at reset values");

  a_flush_paged: assert property (
    (wr_fire && aligned && idx == IDX_FLUSH)
    |=> (datapath_flush & $past(main_converter_page_select))
        == ($past(main_converter_page_select)
            & {NUM_CONV{$past(wbyte[FLUSH_BIT])}})
        && (datapath_flush & ~$past(main_converter_page_select))
           == ($past(datapath_flush) & ~$past(main_converter_page_select)))
    else $error("flush copy not reached through page select");

  a_flush_reserved: assert property (
    (s_setup and (idx == IDX_FLUSH && aligned && !apb_req.pwrite))
    |=> apb_rsp.prdata[DATA_W-1:1] == 31'h0000_0000
        && apb_rsp.prdata[FLUSH_BIT] == $past(flush_rd))
    else $error("flush register readback wrong");

  a_page_write: assert property (
    (wr_fire && aligned && idx == IDX_PAGE)
    |=> main_converter_page_select == $past(apb_req.pwdata[NUM_CONV-1:0]))
    else $error("page select write lost");

  a_boot_self_clear: assert property (
    (boot_loader_start && (loader_evt.finished_ok || loader_evt.failed)
     && !(wr_fire && idx == IDX_BOOT))
    |=> !boot_loader_start)
    else $error("boot loader start did not self clear");

  a_boot_done_ok: assert property (
    $rose(boot_loader_done) |-> $past(loader_evt.finished_ok)
                                && $past(boot_loader_start))
    else $error("done set without successful completion");

  // boot loader readback and outcomes
  a_boot_readback: assert property (
    (s_setup and (idx == IDX_BOOT && aligned && !apb_req.pwrite))
    |=> apb_rsp.prdata[BOOT_DONE_BIT] == $past(boot_loader_done)
        && apb_rsp.prdata[BOOT_START_BIT] == $past(boot_loader_start))
    else $error("boot register readback wrong");

  a_start_by_write: assert property (
    $rose(boot_loader_start) |-> $past(wr_fire) && $past(aligned)
                                 && $past(idx) == IDX_BOOT)
    else $error("boot loader start rose without a write");

  a_fail_no_done: assert property (
    (boot_loader_start && loader_evt.failed && !loader_evt.finished_ok
     && !boot_loader_done) |=> !boot_loader_done)
    else $error("done set after loader failure");

  a_idle_outcome: assert property (
    (!boot_loader_start && loader_evt.finished_ok && !wr_fire)
    |=> boot_loader_done == $past(boot_loader_done))
    else $error("done changed by an outcome while idle");

  a_irq_level: assert property (
    (irq_status & irq_enable) != IRQ_RST |-> irq)
    else $error("interrupt low while enabled status set");

  // sticky status and interrupt level
  a_status_sticky: assert property (
    (irq_status & ~irq_clr) != IRQ_RST
    |=> (irq_status & $past(irq_status & ~irq_clr))
        == $past(irq_status & ~irq_clr))
    else $error("status bit lost without a clear");

  a_set_beats_clear: assert property (
    (irq_set & irq_clr) != IRQ_RST
    |=> (irq_status & $past(irq_set)) == $past(irq_set))
    else $error("clear beat a same-cycle set");

  a_irq_low: assert property (
    (irq_status & irq_enable) == IRQ_RST |-> !irq)
    else $error("interrupt high with no enabled status bit");

endmodule

// ==== misc_irq_flush_boot_pll_regs_tb.sv ====
// self-checking bench for the misc control register bank
module misc_irq_flush_boot_pll_regs_tb
  import misc_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    sys_clk;
  logic                    nrst;
  apb_req_type             apb_req;
  apb_rsp_type             apb_rsp;
  logic [NUM_LINK_SRC-1:0] link_event;
  loader_evt_type          loader_evt;
  logic                    boot_loader_start;
  logic [1:0]              datapath_flush;
  logic [REG_W-1:0]        synth_powerdown0;
  logic [REG_W-1:0]        synth_powerdown1;
  logic                    irq;
  logic [DATA_W-1:0]       rdat;
  logic                    rerr;
  int                      error_cnt;
  int                      num_checks;

  misc_irq_flush_boot_pll_regs #(.NUM_CONV(2)) dut (
    .sys_clk           (sys_clk),
    .nrst              (nrst),
    .apb_req           (apb_req),
    .apb_rsp           (apb_rsp),
    .link_event        (link_event),
    .loader_evt        (loader_evt),
    .boot_loader_start (boot_loader_start),
    .datapath_flush    (datapath_flush),
    .synth_powerdown0  (synth_powerdown0),
    .synth_powerdown1  (synth_powerdown1),
    .irq               (irq)
  );

  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // one apb transfer; ports are settled when it returns
  task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx,
                      input logic [31:0] wd, input logic [1:0] off);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= {idx, off};
    apb_req.pwdata  <= wd;
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    // wait for pready under a bounded count
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    #1;
  endtask

  // read a register and compare its data and error flag
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp,
                    input logic err, input string nm);
    xfer(1'b0, idx, 32'h0000_0000, WORD_ALIGN);
    chk(nm, exp, rdat);
    chk("pslverr", {31'h0, err}, {31'h0, rerr});
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d, WORD_ALIGN);
  endtask

  // one-cycle link event pulse
  task automatic link_pulse(input logic [NUM_LINK_SRC-1:0] v);
    @(posedge sys_clk);
    link_event <= v;
    @(posedge sys_clk);
    link_event <= '0;
    #1;
  endtask

  // one-cycle loader outcome pulse
  task automatic loader_pulse(input logic ok, input logic bad);
    @(posedge sys_clk);
    loader_evt.finished_ok <= ok;
    loader_evt.failed      <= bad;
    @(posedge sys_clk);
    loader_evt <= '0;
    #1;
  endtask

  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end

  // main sequence
  initial begin
    sys_clk    = 1'b0;
    nrst       = 1'b0;
    apb_req    = '0;
    link_event = '0;
    loader_evt = '0;
    error_cnt  = 0;
    num_checks = 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    // reset values
    chk("pd0 port", 32'h02, {24'h0, synth_powerdown0});
    chk("pd1 port", 32'h00, {24'h0, synth_powerdown1});
    chk("irq", 32'h0, {31'h0, irq});
    rd(IDX_LINK_EN_LO, 32'h00, 1'b0, "link en lo");
    rd(IDX_LINK_EN_HI, 32'h00, 1'b0, "link en hi");
    rd(IDX_BOOT, 32'h00, 1'b0, "boot reset");
    rd(IDX_PAGE, 32'h03, 1'b0, "page reset");
    loader_pulse(1'b1, 1'b0);
    rd(IDX_BOOT, 32'h00, 1'b0, "boot idle");
    rd(IDX_IRQ_STATUS, 32'h000, 1'b0, "status idle");
    $display("reset test done");
    // enable field widths and reserved bits
    wr(IDX_LINK_EN_LO, 32'hffff_ffff);
    wr(IDX_LINK_EN_HI, 32'hffff_ffff);
    rd(IDX_LINK_EN_LO, 32'hff, 1'b0, "link en lo");
    rd(IDX_LINK_EN_HI, 32'h01, 1'b0, "link en hi");
    rd(12'h100, 32'h0, 1'b1, "unmapped");
    $display("enable field test done");
    // gated link sources, masking and clearing
    wr(IDX_LINK_EN_LO, 32'h08);
    wr(IDX_LINK_EN_HI, 32'h00);
    wr(IDX_IRQ_ENABLE, 32'h7ff);
    link_pulse(9'h1ff);
    chk("irq set", 32'h1, {31'h0, irq});
    rd(IDX_IRQ_STATUS, 32'h008, 1'b0, "status bit3");
    wr(IDX_IRQ_ENABLE, 32'h000);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_ENABLE, 32'h7ff);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_CLEAR, 32'h008);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(IDX_IRQ_STATUS, 32'h000, 1'b0, "status clr");
    wr(IDX_LINK_EN_LO, 32'h00);
    wr(IDX_LINK_EN_HI, 32'h01);
    link_pulse(9'h1ff);
    rd(IDX_IRQ_STATUS, 32'h100, 1'b0, "status bit8");
    wr(IDX_LINK_EN_LO, 32'h08);
    @(posedge sys_clk);
    link_event <= 9'h008;
    wr(IDX_IRQ_CLEAR, 32'h7ff);
    @(posedge sys_clk);
    link_event <= '0;
    rd(IDX_IRQ_STATUS, 32'h008, 1'b0, "set beats clr");
    rd(IDX_IRQ_CLEAR, 32'h000, 1'b0, "clear reads 0");
    wr(IDX_IRQ_CLEAR, 32'h7ff);
    $display("interrupt test done");
    // paged flush enable
    wr(IDX_PAGE, 32'h1);
    wr(IDX_FLUSH, 32'hff);
    chk("flush p1", 32'h1, {30'h0, datapath_flush});
    rd(IDX_FLUSH, 32'h01, 1'b0, "flush rd");
    wr(IDX_PAGE, 32'h2);
    rd(IDX_FLUSH, 32'h00, 1'b0, "flush p2");
    wr(IDX_FLUSH, 32'h1);
    chk("flush both", 32'h3, {30'h0, datapath_flush});
    wr(IDX_PAGE, 32'h3);
    wr(IDX_FLUSH, 32'h0);
    chk("flush off", 32'h0, {30'h0, datapath_flush});
    $display("flush test done");
    // boot loader failure then success
    wr(IDX_BOOT, 32'h03);
    chk("start", 32'h1, {31'h0, boot_loader_start});
    rd(IDX_BOOT, 32'h01, 1'b0, "boot run");
    loader_pulse(1'b0, 1'b1);
    rd(IDX_BOOT, 32'h00, 1'b0, "boot fail");
    wr(IDX_BOOT, 32'h01);
    loader_pulse(1'b1, 1'b0);
    chk("start clr", 32'h0, {31'h0, boot_loader_start});
    rd(IDX_BOOT, 32'h02, 1'b0, "boot ok");
    rd(IDX_IRQ_STATUS, 32'h600, 1'b0, "status boot");
    $display("boot test done");
    // synthesizer bypass power-down
    wr(IDX_SYNTH_PD0, 32'hff);
    wr(IDX_SYNTH_PD1, 32'h1f);
    chk("pd0 byp", 32'hff, {24'h0, synth_powerdown0});
    rd(IDX_SYNTH_PD1, 32'h1f, 1'b0, "pd1 byp");
    xfer(1'b1, IDX_SYNTH_PD1, 32'h55, 2'h1);
    chk("unaligned err", 32'h1, {31'h0, rerr});
    rd(IDX_SYNTH_PD1, 32'h1f, 1'b0, "pd1 kept");
    wr(IDX_SYNTH_PD0, 32'h00);
    chk("pd0 use", 32'h00, {24'h0, synth_powerdown0});
    $display("synth test done");
    // second reset in mid-run
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk("pd0 again", 32'h02, {24'h0, synth_powerdown0});
    chk("pd1 again", 32'h00, {24'h0, synth_powerdown1});
    chk("flush again", 32'h0, {30'h0, datapath_flush});
    chk("irq again", 32'h0, {31'h0, irq});
    rd(IDX_LINK_EN_HI, 32'h00, 1'b0, "link hi again");
    rd(IDX_PAGE, 32'h03, 1'b0, "page again");
    $display("second reset test done");
    end_of_test();
  end
endmodule
